//--- pkg/bbs_pkg.sv
// Constants and helpers shared by the buffer base state command ends
package bbs_pkg;

    // ****************************************
    // Command header fields
    // ****************************************
    localparam logic [2:0]  HDR_CMD_TYPE  = 3'h3;      // Parallel video pipe class
    localparam logic [1:0]  HDR_PIPELINE  = 2'h2;      // Bitstream decoder unit
    localparam logic [2:0]  HDR_OPCODE    = 3'h4;      // Video opcode
    localparam logic [7:0]  HDR_SUBOPCODE = 8'h03;     // Buffer base state sub-opcode
    localparam logic [15:0] HDR_LENGTH    = 16'h0048;  // Dwords beyond the first two

    // ****************************************
    // Payload layout: entry n holds dword n+1
    // ****************************************
    localparam int         NUM_PAYLOAD    = 73;        // Dwords 1 to 73
    localparam logic [6:0] LAST_PAYLOAD   = 7'h48;     // Index of dword 73
    localparam int         IDX_BS_ROW     = 0;         // Bitstream row store base
    localparam int         IDX_MVP_ROW    = 1;         // Motion vector prediction row store
    localparam int         IDX_MB_INFO    = 2;         // Macroblock info base
    localparam int         IDX_IT_DATA    = 3;         // Inverse transform data base/offset
    localparam int         IDX_DEBLOCK    = 4;         // Deblock output base
    localparam int         IDX_COL_RD0    = 5;         // First co-located read base
    localparam int         IDX_COL_WR_TOP = 37;        // Co-located write, top/frame
    localparam int         IDX_COL_WR_BOT = 38;        // Co-located write, bottom
    localparam int         IDX_POC0       = 39;        // First picture order entry
    localparam logic [5:0] POC_LAST       = 6'h21;     // Entry 33

    // ****************************************
    // Addressing constants
    // ****************************************
    localparam logic [31:0] BS_ROW_PAIR   = 32'h0000_0060;  // 1.5 lines per pair column
    localparam logic [31:0] BS_ROW_SINGLE = 32'h0000_0030;  // 0.75 line per macroblock
    localparam logic [31:0] MVP_PAIR      = 32'h0000_0040;  // 1 line per pair column
    localparam logic [31:0] MVP_SINGLE    = 32'h0000_0020;  // Half line per macroblock
    localparam logic [31:0] LINE_BYTES    = 32'h0000_0040;  // One cache line
    localparam logic [31:0] DEBLOCK_BYTES = 32'h0000_0080;  // Two lines per macroblock
    localparam logic [31:0] IT_SLOT_BYTES = 32'h0000_0800;  // Fixed slot per macroblock
    localparam logic [31:0] COL_PITCH_MBS = 32'h0000_0080;  // Fixed 128-macroblock rows
    localparam logic [4:0]  STORE_WRITE   = 5'h10;          // Index using write bases

    // ****************************************
    // Issuer register map (byte offsets)
    // ****************************************
    localparam logic [3:0]  REG_CTRL      = 4'h0;      // Start / new stream
    localparam logic [3:0]  REG_DATA      = 4'h4;      // Payload dword to send
    localparam logic [3:0]  REG_STATUS    = 4'h8;      // Progress and state
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_NEWSTRM  = 1;

    // Header word built from the fields above
    function automatic logic [31:0] make_header();
        return {HDR_CMD_TYPE, HDR_PIPELINE, HDR_OPCODE, HDR_SUBOPCODE, HDR_LENGTH};
    endfunction

    // 64-byte aligned base taken from a dword
    function automatic logic [31:0] line_base(input logic [31:0] w);
        return {w[31:6], 6'h00};
    endfunction

endpackage

//--- pkg/bbs_link_if.sv
// Command link between the issuer and the buffer base state device
`timescale 1ns/100ps
interface bbs_link_if (
    input wire logic clk_i
);
    logic        cmd_valid;  // Issuer offers a dword
    logic        cmd_ready;  // Device accepts it
    logic [31:0] cmd_data;   // Command dword

    // Device end
    modport device (input cmd_valid, input cmd_data, output cmd_ready);
    // Issuer end
    modport issuer (output cmd_valid, output cmd_data, input cmd_ready);
endinterface

//--- src/bbs_addr_gen.sv
// Combinational address generation from loaded buffer bases
`timescale 1ns/100ps
module bbs_addr_gen
    import bbs_pkg::*;
(
    input  wire logic [31:0] bs_row_base_i,
    input  wire logic [31:0] mvp_row_base_i,
    input  wire logic [31:0] mb_info_base_i,
    input  wire logic [31:0] it_data_i,
    input  wire logic [31:0] deblock_base_i,
    input  wire logic [31:0] col_rd_sel_i,
    input  wire logic [31:0] col_wr_sel_i,
    input  wire logic [7:0]  mb_x_i,
    input  wire logic [7:0]  mb_y_i,
    input  wire logic [13:0] mb_num_i,
    input  wire logic        pair_mode_i,
    output logic      [31:0] bs_row_addr_o,
    output logic      [31:0] mvp_row_addr_o,
    output logic      [31:0] mb_info_addr_o,
    output logic      [31:0] it_write_addr_o,
    output logic      [31:0] it_indirect_o,
    output logic      [31:0] deblock_addr_o,
    output logic      [31:0] col_rd_addr_o,
    output logic      [31:0] col_wr_addr_o
);
    logic [31:0] x32;      // Horizontal position
    logic [31:0] num32;    // Macroblock number
    logic [31:0] col_off;  // Co-located offset
    logic [31:0] it_slot;  // Inverse transform slot offset

    assign x32   = {24'h0, mb_x_i};
    assign num32 = {18'h0, mb_num_i};

    // Row stores indexed by horizontal position
    assign bs_row_addr_o  = line_base(bs_row_base_i)
                          + x32 * (pair_mode_i ? BS_ROW_PAIR : BS_ROW_SINGLE);
    assign mvp_row_addr_o = line_base(mvp_row_base_i)
                          + x32 * (pair_mode_i ? MVP_PAIR : MVP_SINGLE);

    // One line per macroblock by macroblock number
    assign mb_info_addr_o = line_base(mb_info_base_i) + num32 * LINE_BYTES;

    // Fixed slot per macroblock; indirect start ignores the 4KB base
    assign it_slot         = num32 * IT_SLOT_BYTES;
    assign it_write_addr_o = {it_data_i[31:12], it_data_i[11:6], 6'h00} + it_slot;
    assign it_indirect_o   = {20'h0, it_data_i[11:6], 6'h00} + it_slot;

    // Two lines reserved per macroblock
    assign deblock_addr_o = line_base(deblock_base_i) + num32 * DEBLOCK_BYTES;

    // Co-located buffers use a fixed 128-macroblock row pitch
    assign col_off       = ({24'h0, mb_y_i} * COL_PITCH_MBS + x32) * LINE_BYTES;
    assign col_rd_addr_o = line_base(col_rd_sel_i) + col_off;
    assign col_wr_addr_o = line_base(col_wr_sel_i) + col_off;
endmodule

//--- src/bbs_device.sv
// Buffer base state command handler on the decoder side
`timescale 1ns/100ps
module bbs_device
    import bbs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    bbs_link_if.device       link,
    input  wire logic [7:0]  mb_x_i,
    input  wire logic [7:0]  mb_y_i,
    input  wire logic [13:0] mb_num_i,
    input  wire logic        pair_mode_i,
    input  wire logic        bottom_field_i,
    input  wire logic [4:0]  decoded_frame_store_index_i,
    input  wire logic [4:0]  ref_index_i,
    input  wire logic [5:0]  frame_slot_id_i,
    input  wire logic        slot_bottom_i,
    output logic      [31:0] bs_row_addr_o,
    output logic      [31:0] mvp_row_addr_o,
    output logic      [31:0] mb_info_addr_o,
    output logic      [31:0] it_write_addr_o,
    output logic      [31:0] it_indirect_o,
    output logic      [31:0] deblock_addr_o,
    output logic      [31:0] col_rd_addr_o,
    output logic      [31:0] col_wr_addr_o,
    output logic             col_wr_valid_o,
    output logic      [31:0] poc_value_o,
    output logic             state_loaded_o,
    output logic             load_busy_o,
    output logic             bad_header_o
);

    // ****************************************
    // Types and state
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE,    // Waiting for a header
        ST_LOAD,    // Collecting payload dwords
        ST_COMMIT   // Moving staged values live
    } state_t;

    state_t      state_q;                       // Parser state
    logic [6:0]  cnt_q;                         // Payload index being received
    logic        ready_q;                       // Link ready
    logic [31:0] stage_q [NUM_PAYLOAD];         // Staged payload
    logic [31:0] live_q  [NUM_PAYLOAD];         // Values used by decoding
    logic        loaded_q;                      // A full command has been applied
    logic        bad_q;                         // Rejected header pulse
    logic        take;                          // Dword handshake this cycle
    logic        last_take;                     // Final payload dword accepted

    // Derived selections
    logic [31:0] col_rd_sel;                    // Read base for a reference
    logic [31:0] col_wr_sel;                    // Write base for current picture
    logic        col_wr_ok;                     // Store index is in range
    logic [5:0]  poc_idx;                       // Picture order index

    // Generator results
    logic [31:0] g_bs_row;
    logic [31:0] g_mvp_row;
    logic [31:0] g_mb_info;
    logic [31:0] g_it_write;
    logic [31:0] g_it_ind;
    logic [31:0] g_deblock;
    logic [31:0] g_col_rd;
    logic [31:0] g_col_wr;

    // ****************************************
    // Header decode
    // ****************************************

    // True only for a well formed buffer base state header
    function automatic logic header_ok(input logic [31:0] w);
        return (w[31:29] == HDR_CMD_TYPE)
            && (w[28:27] == HDR_PIPELINE)
            && (w[26:24] == HDR_OPCODE)
            && (w[23:16] == HDR_SUBOPCODE)
            && (w[15:0]  == HDR_LENGTH);
    endfunction

    assign take      = link.cmd_valid && ready_q;
    assign last_take = take && (state_q == ST_LOAD) && (cnt_q == LAST_PAYLOAD);

    // ****************************************
    // Command parser
    // ****************************************

    // Parser sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 7'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Other headers are dropped one dword at a time
                    if (take && header_ok(link.cmd_data)) begin
                        state_q <= ST_LOAD;
                        cnt_q   <= 7'h00;
                    end
                end
                ST_LOAD: begin
                    // Exactly the length field's count plus dword 1
                    if (take) begin
                        if (cnt_q == LAST_PAYLOAD) begin
                            state_q <= ST_COMMIT;
                        end else begin
                            cnt_q <= cnt_q + 7'h01;
                        end
                    end
                end
                ST_COMMIT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Link ready, dropped for the commit cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= !last_take;
        end
    end

    // Rejected header pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_q <= 1'b0;
        end else begin
            bad_q <= take && (state_q == ST_IDLE) && !header_ok(link.cmd_data);
        end
    end

    // ****************************************
    // Storage
    // ****************************************

    // Staging keeps a partial command away from decoding
    always_ff @(posedge clk_i) begin
        if (take && (state_q == ST_LOAD)) begin
            stage_q[cnt_q] <= link.cmd_data;
        end
    end

    // Live values cleared by reset and replaced only by a complete command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_PAYLOAD; i++) begin
                live_q[i] <= 32'h0000_0000;
            end
        end else if (state_q == ST_COMMIT) begin
            for (int i = 0; i < NUM_PAYLOAD; i++) begin
                live_q[i] <= stage_q[i];
            end
        end
    end

    // Loaded flag after the first commit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loaded_q <= 1'b0;
        end else if (state_q == ST_COMMIT) begin
            loaded_q <= 1'b1;
        end
    end

    // ****************************************
    // Base selection
    // ****************************************

    // Co-located read base for a reference frame
    assign col_rd_sel = live_q[IDX_COL_RD0 + int'(ref_index_i)];

    // Co-located write base for the current picture
    always_comb begin
        col_wr_sel = 32'h0000_0000;
        col_wr_ok  = 1'b0;
        if (decoded_frame_store_index_i < STORE_WRITE) begin
            col_wr_sel = live_q[IDX_COL_RD0 + int'(decoded_frame_store_index_i)];
            col_wr_ok  = 1'b1;
        end else if (decoded_frame_store_index_i == STORE_WRITE) begin
            col_wr_ok = 1'b1;
            if (bottom_field_i) begin
                col_wr_sel = live_q[IDX_COL_WR_BOT];
            end else begin
                col_wr_sel = live_q[IDX_COL_WR_TOP];
            end
        end
    end

    // Slot id bits 5:1 with field parity; frame callers keep parity low
    assign poc_idx = {frame_slot_id_i[5:1], slot_bottom_i};

    // ****************************************
    // Address generation
    // ****************************************
    bbs_addr_gen bbs_addr_gen_i (
        .bs_row_base_i  (live_q[IDX_BS_ROW]),
        .mvp_row_base_i (live_q[IDX_MVP_ROW]),
        .mb_info_base_i (live_q[IDX_MB_INFO]),
        .it_data_i      (live_q[IDX_IT_DATA]),
        .deblock_base_i (live_q[IDX_DEBLOCK]),
        .col_rd_sel_i   (col_rd_sel),
        .col_wr_sel_i   (col_wr_sel),
        .mb_x_i         (mb_x_i),
        .mb_y_i         (mb_y_i),
        .mb_num_i       (mb_num_i),
        .pair_mode_i    (pair_mode_i),
        .bs_row_addr_o  (g_bs_row),
        .mvp_row_addr_o (g_mvp_row),
        .mb_info_addr_o (g_mb_info),
        .it_write_addr_o(g_it_write),
        .it_indirect_o  (g_it_ind),
        .deblock_addr_o (g_deblock),
        .col_rd_addr_o  (g_col_rd),
        .col_wr_addr_o  (g_col_wr)
    );

    // ****************************************
    // Output registers
    // ****************************************

    // Addresses registered one cycle after the query
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bs_row_addr_o   <= 32'h0000_0000;
            mvp_row_addr_o  <= 32'h0000_0000;
            mb_info_addr_o  <= 32'h0000_0000;
            it_write_addr_o <= 32'h0000_0000;
            it_indirect_o   <= 32'h0000_0000;
            deblock_addr_o  <= 32'h0000_0000;
            col_rd_addr_o   <= 32'h0000_0000;
            col_wr_addr_o   <= 32'h0000_0000;
            col_wr_valid_o  <= 1'b0;
        end else begin
            bs_row_addr_o   <= g_bs_row;
            mvp_row_addr_o  <= g_mvp_row;
            mb_info_addr_o  <= g_mb_info;
            it_write_addr_o <= g_it_write;
            it_indirect_o   <= g_it_ind;
            deblock_addr_o  <= g_deblock;
            col_rd_addr_o   <= g_col_rd;
            col_wr_addr_o   <= g_col_wr;
            col_wr_valid_o  <= col_wr_ok;
        end
    end

    // Picture order value; indices past 33 read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            poc_value_o <= 32'h0000_0000;
        end else if (poc_idx > POC_LAST) begin
            poc_value_o <= 32'h0000_0000;
        end else begin
            poc_value_o <= live_q[IDX_POC0 + int'(poc_idx)];
        end
    end

    // Status outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_loaded_o <= 1'b0;
            load_busy_o    <= 1'b0;
            bad_header_o   <= 1'b0;
        end else begin
            state_loaded_o <= loaded_q;
            load_busy_o    <= (state_q != ST_IDLE);
            bad_header_o   <= bad_q;
        end
    end

    assign link.cmd_ready = ready_q;
endmodule

//--- src/bbs_issuer.sv
// Issuer end: Wishbone registers that send the buffer base state command
`timescale 1ns/100ps
module bbs_issuer
    import bbs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    bbs_link_if.issuer       link,
    input  wire logic [3:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    output logic             slice_enable_o
);

    // ****************************************
    // State
    // ****************************************
    logic        valid_q;    // Dword on the link
    logic [31:0] data_q;     // Dword value
    logic [6:0]  left_q;     // Payload dwords still owed
    logic        reload_q;   // Stream changed, command owed
    logic        sent_q;     // A full command went out
    logic        req;        // New bus request
    logic        send_hdr;   // Start write
    logic        send_dat;   // Payload write
    logic        hs;         // Link handshake

    assign req      = cyc_i && stb_i && !ack_o && !valid_q;
    assign send_hdr = req && we_i && (adr_i == REG_CTRL) && sel_i[0] && dat_i[CTRL_START]
                      && (left_q == 7'h00);
    assign send_dat = req && we_i && (adr_i == REG_DATA) && (left_q != 7'h00);
    assign hs       = valid_q && link.cmd_ready;

    // ****************************************
    // Link driver
    // ****************************************

    // Holds each dword until the device takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            data_q  <= 32'h0000_0000;
        end else if (send_hdr) begin
            valid_q <= 1'b1;
            data_q  <= make_header();
        end else if (send_dat) begin
            valid_q <= 1'b1;
            data_q  <= dat_i;
        end else if (hs) begin
            valid_q <= 1'b0;
        end
    end

    // Payload countdown: full 73 dwords always
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_q <= 7'h00;
        end else if (send_hdr) begin
            left_q <= LAST_PAYLOAD + 7'h01;
        end else if (send_dat) begin
            left_q <= left_q - 7'h01;
        end
    end

    // Stream change forces a resend before slices run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_q <= 1'b0;
            sent_q   <= 1'b0;
        end else begin
            if (send_dat && (left_q == 7'h01)) begin
                reload_q <= 1'b0;
                sent_q   <= 1'b1;
            end
            if (req && we_i && (adr_i == REG_CTRL) && sel_i[0] && dat_i[CTRL_NEWSTRM]) begin
                reload_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Bus answer
    // ****************************************

    // Writes to the link ack on handshake; others next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ack_o) begin
            ack_o <= 1'b0;
        end else if (hs) begin
            ack_o <= 1'b1;
        end else if (req && !send_hdr && !send_dat) begin
            ack_o <= 1'b1;
            dat_o <= 32'h0000_0000;
            if (!we_i && (adr_i == REG_STATUS)) begin
                dat_o <= {21'h0, reload_q, sent_q, valid_q, 1'b0, left_q};  // Bit 7 spare
            end
        end
    end

    // Slice decoding allowed once state is current
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slice_enable_o <= 1'b0;
        end else begin
            slice_enable_o <= sent_q && !reload_q && (left_q == 7'h00) && !valid_q;
        end
    end

    assign link.cmd_valid = valid_q;
    assign link.cmd_data  = data_q;
endmodule

//--- testbench/bbs_link_checker.sv
// Link protocol checks for the buffer base state command
`timescale 1ns/100ps
module bbs_link_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [31:0] cmd_data
);
    logic [6:0] n_q;                      // Dwords taken in this command
    wire        hs = cmd_valid && cmd_ready;
    // Count header and payload dwords
    always_ff @(posedge clk_i) begin
        if (rst_i || (hs && n_q == 7'h49)) n_q <= 7'h0;
        else if (hs) n_q <= n_q + 7'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_head; hs && n_q == 7'h0; endsequence
    sequence s_last; hs && n_q == 7'h49; endsequence
    property p_class; s_head |-> cmd_data[31:29] == 3'h3; endproperty
    property p_ident; s_head |-> cmd_data[28:16] == {2'h2, 3'h4, 8'h03}; endproperty
    property p_len; s_head |-> cmd_data[15:0] == 16'h0048; endproperty
    property p_commit; s_last |=> !cmd_ready ##1 cmd_ready; endproperty
    property p_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data); endproperty
    property p_rst; $fell(rst_i) |-> !cmd_ready ##[1:2] cmd_ready; endproperty
    property p_flow; hs && n_q != 7'h49 |=> cmd_ready; endproperty
    property p_end; s_last |=> !cmd_valid; endproperty
    a_class: assert property (p_class) else $error("bad command class");
    a_ident: assert property (p_ident) else $error("bad command id");
    a_len: assert property (p_len) else $error("bad length");
    a_commit: assert property (p_commit) else $error("no commit gap");
    a_hold: assert property (p_hold) else $error("dword changed early");
    a_rst: assert property (p_rst) else $error("ready after reset");
    a_flow: assert property (p_flow) else $error("ready dropped");
    a_end: assert property (p_end) else $error("extra dword");
endmodule

//--- testbench/avc_decode_buffer_base_state_tb.sv
// Self-checking bench joining issuer and device
`timescale 1ns/100ps
module avc_decode_buffer_base_state_tb;
    import bbs_pkg::*;
    logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o, slice_enable_o;
    logic        pair_mode_i = 0, bottom_field_i = 0, slot_bottom_i = 0, col_wr_valid_o;
    logic        state_loaded_o, load_busy_o, bad_header_o;
    logic [3:0]  adr_i = 0, sel_i = 4'hf;
    logic [4:0]  decoded_frame_store_index_i = 0, ref_index_i = 0;
    logic [5:0]  frame_slot_id_i = 0;
    logic [7:0]  mb_x_i = 0, mb_y_i = 0;
    logic [13:0] mb_num_i = 0;
    logic [31:0] dat_i = 0, dat_o, bs_row_addr_o, mvp_row_addr_o, mb_info_addr_o, it_write_addr_o;
    logic [31:0] it_indirect_o, deblock_addr_o, col_rd_addr_o, col_wr_addr_o, poc_value_o;
    logic [31:0] p [NUM_PAYLOAD];          // Payload of the loaded command
    logic [31:0] rd_data;                  // Read data taken at ack
    int          err_count = 0, checks_done = 0;
    bbs_link_if link (.clk_i(clk_i));
    bbs_device bbs_device_i (.*);
    bbs_issuer bbs_issuer_i (.*);
    bbs_link_checker bbs_link_checker_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid(link.cmd_valid),
        .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    function automatic logic [31:0] lb(input logic [31:0] w);
        return {w[31:6], 6'h00};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // Classic Wishbone cycle, held until ack
    task automatic wb(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {adr_i, we_i, dat_i, cyc_i, stb_i} <= {a, a != REG_STATUS, d, 2'b11};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        rd_data = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (n >= 50) begin
            err_count++;
            report_and_stop();
        end
    endtask
    // One lookup with random position
    task automatic q(input logic [4:0] idx);
        logic [7:0]  x, y;
        logic [13:0] n;
        logic [4:0]  r;
        logic [5:0]  s;
        logic        pr, bt, sb;
        logic [31:0] cw;
        {x, y, n, r, pr, bt, sb} = 38'({$urandom, $urandom});
        s = 6'($urandom % 34);
        {mb_x_i, mb_y_i, mb_num_i, pair_mode_i, bottom_field_i} <= {x, y, n, pr, bt};
        {decoded_frame_store_index_i, ref_index_i, frame_slot_id_i, slot_bottom_i} <= {idx, r, s, sb};
        repeat (2) @(posedge clk_i);
        cw = (32'(y) * 32'h80 + 32'(x)) * 32'h40;
        chk("bs_row", lb(p[0]) + 32'(x) * (pr ? 32'h60 : 32'h30), bs_row_addr_o);
        chk("mvp_row", lb(p[1]) + 32'(x) * (pr ? 32'h40 : 32'h20), mvp_row_addr_o);
        chk("mb_info", lb(p[2]) + 32'(n) * 32'h40, mb_info_addr_o);
        chk("it_write", lb(p[3]) + 32'(n) * 32'h800, it_write_addr_o);
        chk("it_indirect", {20'h0, p[3][11:6], 6'h0} + 32'(n) * 32'h800, it_indirect_o);
        chk("deblock", lb(p[4]) + 32'(n) * 32'h80, deblock_addr_o);
        chk("col_rd", lb(p[5 + r]) + cw, col_rd_addr_o);
        cw = (idx == 16 ? lb(p[bt ? 38 : 37]) : idx < 16 ? lb(p[5 + idx]) : 32'h0) + cw;
        chk("col_wr", cw, col_wr_addr_o);
        chk("col_wr_valid", {31'h0, idx <= 16}, {31'h0, col_wr_valid_o});
        chk("poc", p[39 + 32'({s[5:1], sb})], poc_value_o);
    endtask
    initial begin
        void'($urandom(17387));
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        wb(REG_STATUS, 0);
        chk("status", 0, rd_data);
        for (int k = 0; k < 2; k++) begin
            foreach (p[i]) p[i] = i < 39 ? $urandom & 32'hffffffc0 : $urandom;
            wb(REG_CTRL, 32'h1);
            @(posedge clk_i);
            chk("busy", 1, {31'h0, load_busy_o});
            chk("loaded", 32'(k), {31'h0, state_loaded_o});
            foreach (p[i]) wb(REG_DATA, p[i]);
            repeat (4) @(posedge clk_i);
            chk("loaded", 1, {31'h0, state_loaded_o});
            chk("slice_enable", 1, {31'h0, slice_enable_o});
            chk("busy", 0, {31'h0, load_busy_o});
            chk("bad_header", 0, {31'h0, bad_header_o});
            wb(REG_STATUS, 0);
            chk("status", 32'h200, rd_data);
            for (int j = 0; j < 10; j++) q(j < 5 ? 5'(j * 4) : 5'(16 + j % 2));
            wb(REG_CTRL, 32'h2);
            @(posedge clk_i);
            chk("slice_enable", 0, {31'h0, slice_enable_o});
            wb(REG_STATUS, 0);
            chk("status", 32'h600, rd_data);
            for (int j = 0; j < 3; j++) q(5'(15 + j));
        end
        // Mid-run reset must clear the loaded flag and the loaded values that one lookup reads
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        foreach (p[i]) p[i] = 0;
        q(5'h03);
        chk("loaded", 0, {31'h0, state_loaded_o});
        report_and_stop();
    end
endmodule
